// ==== pkg/sarf_pkg.sv ====
// shared constants, types and state encoding for the sar result formatter
package sarf_pkg;

   // ==========================================================
   // converter geometry
   localparam int CODE_BITS = 10;
   localparam int SHORT_BITS = 8;
   localparam int BYTE_BITS = 8;
   localparam int DIV_W = 5;
   localparam int TICK_W = 4;

   // ==========================================================
   // conversion length in sar clocks
   localparam logic [TICK_W-1:0] CONV_CLKS_10 = 4'hD;
   localparam logic [TICK_W-1:0] SHORT_SAVING = 4'h2;
   localparam logic [TICK_W-1:0] CONV_CLKS_8 = CONV_CLKS_10 - SHORT_SAVING;
   localparam logic [TICK_W-1:0] SETUP_CLKS = 4'h3;

   // ==========================================================
   // successive approximation trial bits
   localparam logic [CODE_BITS-1:0] TRIAL_MSB = 10'h200;
   localparam logic [CODE_BITS-1:0] LAST_BIT_10 = 10'h001;
   localparam logic [CODE_BITS-1:0] LAST_BIT_8 = 10'h004;
   localparam logic [CODE_BITS-1:0] CODE_ZERO = 10'h000;

   // ==========================================================
   // justification padding and reset values
   localparam logic [5:0] PAD_ZERO = 6'h00;
   localparam logic [BYTE_BITS-1:0] RESULT_RESET = 8'h00;
   localparam logic [TICK_W-1:0] TICK_ZERO = 4'h0;
   localparam logic [TICK_W-1:0] TICK_ONE = 4'h1;
   localparam logic [DIV_W-1:0] DIV_ZERO = 5'h00;
   localparam logic [DIV_W-1:0] DIV_ONE = 5'h01;

   // ==========================================================
   // software configuration carried as one group
   typedef struct packed {
      logic power_on;
      logic left_align;
      logic short_result;
      logic gain_half;
      logic [DIV_W-1:0] divider;
   } sarf_cfg_s;

   // formatted result byte pair
   typedef struct packed {
      logic [BYTE_BITS-1:0] high;
      logic [BYTE_BITS-1:0] low;
   } sarf_result_s;

   // conversion sequencer, gray coded along idle-track-resolve-finish
   typedef enum logic [1:0] {
      sarf_idle = 2'h0,
      sarf_track = 2'h1,
      sarf_resolve = 2'h3,
      sarf_finish = 2'h2
   } sarf_state_e;

endpackage

// ==== core/sarf_clk_div.sv ====
// sar conversion clock tick generator divided from the system clock
`timescale 1ns/1ps
module sarf_clk_div
   import sarf_pkg::*;
#(
   parameter int W = DIV_W
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // control
   input wire logic run,
   input wire logic [W-1:0] divider,
   // tick out
   output logic sar_tick
);

   // ==========================================================
   // divide counter
   logic [W-1:0] cnt;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         cnt <= '0;
         sar_tick <= 1'b0;
      end else if (!run) begin
         cnt <= '0;
         sar_tick <= 1'b0;
      end else if (cnt == divider) begin
         cnt <= '0;
         sar_tick <= 1'b1; // see [R13]
      end else begin
         cnt <= cnt + W'(1);
         sar_tick <= 1'b0;
      end
   end

   // ==========================================================
   // checks
   a_div_tick_due: assert property ( // see [R13]
      @(posedge clk_sys) disable iff (!rst_n)
      run && (cnt == divider) |=> sar_tick
   ) else $error("sar tick missing at end of divide period");

   a_div_tick_cause: assert property ( // see [R13]
      @(posedge clk_sys) disable iff (!rst_n)
      sar_tick |-> $past(run) && ($past(cnt) == $past(divider))
   ) else $error("sar tick outside divide period end");

endmodule

// ==== core/sarf_result_fmt.sv ====
// sar converter control, sequencing and result formatting
`timescale 1ns/1ps
// What this block does
// [R1] converter runs only while power bit set
// [R2] result is unsigned ten bit code
// [R3] right aligned code in low ten bits
// [R4] left aligned code in top ten bits
// [R5] unused result bits read zero
// [R6] result bytes load at conversion end
// [R7] short mode resolves eight bits, high byte
// [R8] short mode ignores left align bit
// [R9] short conversion two sar clocks shorter
// [R10] gain selectable one or one half
// [R11] busy during conversion, fall sets done
// [R12] software writes start to begin conversion
// [R13] sar clock is system clock over divider+1
// [R14] results held while converter is shut down
module sarf_result_fmt
   import sarf_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // software configuration
   input wire sarf_cfg_s cfg,
   // software commands
   input wire logic start_write,
   input wire logic done_flag_clear,
   // analog comparator from the converter core
   input wire logic comp_in,
   // analog controls
   output logic analog_power_on,
   output logic gain_half,
   output logic sample_hold,
   output logic [CODE_BITS-1:0] dac_trial,
   // status
   output logic conversion_in_progress,
   output logic conversion_done_flag,
   output logic conversion_done_pulse,
   // result
   output logic [BYTE_BITS-1:0] result_high_byte,
   output logic [BYTE_BITS-1:0] result_low_byte
);

   // ==========================================================
   // internal state
   sarf_state_e state;
   logic comp_s1;
   logic comp_s2;
   logic comp_s3;
   logic comp_level;
   logic sar_tick;
   logic short_mode;
   logic left_mode;
   logic [TICK_W-1:0] tick_cnt;
   logic [CODE_BITS-1:0] trial_bit;
   logic [CODE_BITS-1:0] code;
   logic [CODE_BITS-1:0] next_sar;
   logic [CODE_BITS-1:0] last_bit;
   logic start_ok;
   sarf_result_s next_result;

   // ==========================================================
   // sar clock divider
   sarf_clk_div #(
      .W(DIV_W)
   ) u_div (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .run(conversion_in_progress),
      .divider(cfg.divider),
      .sar_tick(sar_tick)
   );

   // ==========================================================
   // comparator synchroniser and agreement filter
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         comp_s1 <= 1'b0;
         comp_s2 <= 1'b0;
         comp_s3 <= 1'b0;
      end else begin
         comp_s1 <= comp_in;
         comp_s2 <= comp_s1;
         comp_s3 <= comp_s2;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         comp_level <= 1'b0;
      end else if (comp_s2 == comp_s3) begin
         comp_level <= comp_s3;
      end
   end

   // ==========================================================
   // analog control levels
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         analog_power_on <= 1'b0;
         gain_half <= 1'b0;
      end else begin
         analog_power_on <= cfg.power_on; // see [R1]
         gain_half <= cfg.gain_half; // see [R10]
      end
   end

   // ==========================================================
   // successive approximation step
   assign start_ok = start_write && cfg.power_on && (state == sarf_idle); // see [R12]
   assign last_bit = short_mode ? LAST_BIT_8 : LAST_BIT_10; // see [R7]

   always_comb begin
      next_sar = dac_trial;
      if (!comp_level) begin
         next_sar = dac_trial & ~trial_bit;
      end
   end

   // ==========================================================
   // conversion sequencer
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state <= sarf_idle;
         conversion_in_progress <= 1'b0;
         sample_hold <= 1'b0;
         tick_cnt <= TICK_ZERO;
         trial_bit <= TRIAL_MSB;
         dac_trial <= CODE_ZERO;
         code <= CODE_ZERO;
         short_mode <= 1'b0;
         left_mode <= 1'b0;
      end else if (!cfg.power_on) begin
         state <= sarf_idle; // see [R1]
         conversion_in_progress <= 1'b0;
         sample_hold <= 1'b0;
         tick_cnt <= TICK_ZERO;
         trial_bit <= TRIAL_MSB;
         dac_trial <= CODE_ZERO;
      end else begin
         case (state)
            sarf_idle: begin
               if (start_ok) begin
                  state <= sarf_track;
                  conversion_in_progress <= 1'b1; // see [R11]
                  sample_hold <= 1'b1;
                  tick_cnt <= TICK_ZERO;
                  trial_bit <= TRIAL_MSB;
                  dac_trial <= TRIAL_MSB;
                  short_mode <= cfg.short_result;
                  left_mode <= cfg.left_align;
               end
            end
            sarf_track: begin
               if (sar_tick) begin
                  tick_cnt <= tick_cnt + TICK_ONE;
                  if (tick_cnt == SETUP_CLKS - TICK_ONE) begin
                     state <= sarf_resolve;
                     sample_hold <= 1'b0;
                  end
               end
            end
            sarf_resolve: begin
               if (sar_tick) begin
                  tick_cnt <= tick_cnt + TICK_ONE; // see [R9]
                  if (trial_bit == last_bit) begin
                     state <= sarf_finish;
                     code <= next_sar; // see [R2]
                     dac_trial <= next_sar;
                  end else begin
                     trial_bit <= trial_bit >> 1;
                     dac_trial <= next_sar | (trial_bit >> 1);
                  end
               end
            end
            sarf_finish: begin
               state <= sarf_idle;
               conversion_in_progress <= 1'b0; // see [R11]
            end
            default: begin
               state <= sarf_idle;
               conversion_in_progress <= 1'b0;
            end
         endcase
      end
   end

   // ==========================================================
   // result formatting
   always_comb begin
      next_result = '0;
      if (short_mode) begin
         next_result.high = code[CODE_BITS-1:CODE_BITS-SHORT_BITS]; // see [R7] see [R8]
         next_result.low = RESULT_RESET; // see [R5]
      end else if (left_mode) begin
         next_result = {code, PAD_ZERO}; // see [R4] see [R5]
      end else begin
         next_result = {PAD_ZERO, code}; // see [R3] see [R5]
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         result_high_byte <= RESULT_RESET;
         result_low_byte <= RESULT_RESET;
      end else if (cfg.power_on && (state == sarf_finish)) begin // see [R14]
         result_high_byte <= next_result.high; // see [R6]
         result_low_byte <= next_result.low;
      end
   end

   // ==========================================================
   // completion flag and pulse
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         conversion_done_flag <= 1'b0;
      end else if (cfg.power_on && (state == sarf_finish)) begin
         conversion_done_flag <= 1'b1; // see [R11]
      end else if (done_flag_clear) begin
         conversion_done_flag <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         conversion_done_pulse <= 1'b0;
      end else begin
         conversion_done_pulse <= cfg.power_on && (state == sarf_finish); // see [R11]
      end
   end

   // ==========================================================
   // checks
   a_off_not_busy: assert property ( // see [R1]
      @(posedge clk_sys) disable iff (!rst_n)
      !cfg.power_on |=> !conversion_in_progress && (state == sarf_idle)
   ) else $error("converter active while shut down");

   a_start_sets_busy: assert property ( // see [R12]
      @(posedge clk_sys) disable iff (!rst_n)
      start_ok |=> conversion_in_progress && sample_hold
   ) else $error("start did not begin a conversion");

   a_fall_sets_done: assert property ( // see [R11]
      @(posedge clk_sys) disable iff (!rst_n)
      $fell(conversion_in_progress) && $past(cfg.power_on)
         |-> conversion_done_flag ##1 !conversion_done_pulse
   ) else $error("busy fall without done flag and single pulse");

   a_done_flag_hold: assert property ( // see [R11]
      @(posedge clk_sys) disable iff (!rst_n)
      conversion_done_flag && !done_flag_clear |=> conversion_done_flag
   ) else $error("done flag lost without clear");

   a_right_pad_zero: assert property ( // see [R3]
      @(posedge clk_sys) disable iff (!rst_n)
      conversion_done_pulse && !short_mode && !left_mode
         |-> (result_high_byte[7:2] == PAD_ZERO) && ({result_high_byte[1:0],
         result_low_byte} == code)
   ) else $error("right aligned result misplaced");

   a_left_pad_zero: assert property ( // see [R4]
      @(posedge clk_sys) disable iff (!rst_n)
      conversion_done_pulse && !short_mode && left_mode
         |-> (result_low_byte[5:0] == PAD_ZERO) && ({result_high_byte,
         result_low_byte[7:6]} == code)
   ) else $error("left aligned result misplaced");

   a_short_high_only: assert property ( // see [R7]
      @(posedge clk_sys) disable iff (!rst_n)
      conversion_done_pulse && short_mode
         |-> (result_low_byte == RESULT_RESET) && (result_high_byte == code[9:2])
   ) else $error("short result not in high byte");

   a_short_low_clean: assert property ( // see [R5]
      @(posedge clk_sys) disable iff (!rst_n)
      (state == sarf_finish) && short_mode |-> code[1:0] == 2'h0
   ) else $error("short conversion resolved low bits");

   a_conv_length: assert property ( // see [R9]
      @(posedge clk_sys) disable iff (!rst_n)
      (state == sarf_finish)
         |-> tick_cnt == (short_mode ? CONV_CLKS_8 : CONV_CLKS_10)
   ) else $error("conversion length in sar clocks wrong");

   a_off_holds_result: assert property ( // see [R14]
      @(posedge clk_sys) disable iff (!rst_n)
      !cfg.power_on |=> $stable(result_high_byte) && $stable(result_low_byte)
   ) else $error("result changed while shut down");

   a_result_on_done: assert property ( // see [R6]
      @(posedge clk_sys) disable iff (!rst_n)
      !conversion_done_pulse && !$past(state == sarf_finish)
         |-> $stable(result_high_byte) && $stable(result_low_byte)
   ) else $error("result changed outside completion");

   a_gain_follows: assert property ( // see [R10]
      @(posedge clk_sys) disable iff (!rst_n)
      $changed(cfg.gain_half) |=> gain_half == $past(cfg.gain_half)
   ) else $error("gain control did not follow software");

endmodule

// ==== verification/sarf_result_fmt_tb.sv ====
// self-checking testbench for the sar result formatter
`timescale 1ns/1ps
module sarf_result_fmt_tb;
   import sarf_pkg::*;

   // ==========================================================
   // stimulus and observation
   logic clk_sys;
   logic rst_n;
   sarf_cfg_s cfg;
   logic start_write;
   logic done_flag_clear;
   logic comp_in;
   logic analog_power_on;
   logic gain_half;
   logic sample_hold;
   logic [CODE_BITS-1:0] dac_trial;
   logic conversion_in_progress;
   logic conversion_done_flag;
   logic conversion_done_pulse;
   logic [BYTE_BITS-1:0] result_high_byte;
   logic [BYTE_BITS-1:0] result_low_byte;
   logic [9:0] vin;
   int err_total;
   int n_tests;

   sarf_result_fmt i_dut (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .cfg(cfg),
      .start_write(start_write),
      .done_flag_clear(done_flag_clear),
      .comp_in(comp_in),
      .analog_power_on(analog_power_on),
      .gain_half(gain_half),
      .sample_hold(sample_hold),
      .dac_trial(dac_trial),
      .conversion_in_progress(conversion_in_progress),
      .conversion_done_flag(conversion_done_flag),
      .conversion_done_pulse(conversion_done_pulse),
      .result_high_byte(result_high_byte),
      .result_low_byte(result_low_byte)
   );

   // ==========================================================
   // clock and comparator stand-in
   always #4 clk_sys = ~clk_sys;

   always @(negedge clk_sys) begin
      comp_in <= (vin >= dac_trial);
   end

   // ==========================================================
   // compare and verdict
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic results;
      $display("tests %0d errors %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // ==========================================================
   // one conversion, optionally with a refused start in mid-run
   task automatic conv(input logic [9:0] v, input logic la, input logic sh,
                       input logic mid, output int cyc);
      logic [15:0] exp;
      int n;
      logic saw;
      logic saw_hold;
      exp = sh ? {v[9:2], 8'h00} : (la ? {v, 6'h00} : {6'h00, v});
      @(negedge clk_sys);
      vin = v;
      cfg.left_align = la;
      cfg.short_result = sh;
      start_write = 1'b1;
      @(negedge clk_sys);
      start_write = 1'b0;
      n = 1;
      saw = 1'b0;
      saw_hold = 1'b0;
      while (conversion_done_pulse !== 1'b1 && n < 1000) begin
         saw = saw | (conversion_in_progress === 1'b1);
         saw_hold = saw_hold | (sample_hold === 1'b1);
         start_write = (mid && n == 40);
         @(negedge clk_sys);
         n++;
      end
      chk(16'(conversion_done_pulse), 16'h0001);
      chk(16'(saw), 16'h0001);
      chk(16'(saw_hold), 16'h0001);
      chk(16'(sample_hold), 16'h0000);
      chk({result_high_byte, result_low_byte}, exp);
      chk(16'(conversion_in_progress), 16'h0000);
      chk(16'(conversion_done_flag), 16'h0001);
      @(negedge clk_sys);
      chk(16'(conversion_done_pulse), 16'h0000);
      chk({result_high_byte, result_low_byte}, exp);
      done_flag_clear = 1'b1;
      @(negedge clk_sys);
      done_flag_clear = 1'b0;
      chk(16'(conversion_done_flag), 16'h0000);
      cyc = n;
   endtask

   // ==========================================================
   // power removed mid-conversion, then a start while off
   task automatic abort_run;
      logic [15:0] held;
      int seen;
      held = {result_high_byte, result_low_byte};
      seen = 0;
      @(negedge clk_sys);
      vin = 10'h3C3;
      start_write = 1'b1;
      @(negedge clk_sys);
      start_write = 1'b0;
      repeat (30) @(negedge clk_sys);
      cfg.power_on = 1'b0;
      repeat (2) @(negedge clk_sys);
      chk(16'(conversion_in_progress), 16'h0000);
      chk(16'(analog_power_on), 16'h0000);
      start_write = 1'b1;
      @(negedge clk_sys);
      start_write = 1'b0;
      repeat (150) begin
         @(negedge clk_sys);
         if (conversion_done_pulse !== 1'b0 || conversion_in_progress !== 1'b0) begin
            seen++;
         end
      end
      chk(16'(seen), 16'h0000);
      chk(16'(conversion_done_flag), 16'h0000);
      chk({result_high_byte, result_low_byte}, held);
      cfg.power_on = 1'b1;
      repeat (2) @(negedge clk_sys);
      chk(16'(analog_power_on), 16'h0001);
   endtask

   // ==========================================================
   // gain select follows software
   task automatic gain_check;
      @(negedge clk_sys);
      cfg.gain_half = 1'b1;
      @(negedge clk_sys);
      chk(16'(gain_half), 16'h0001);
      cfg.gain_half = 1'b0;
      @(negedge clk_sys);
      chk(16'(gain_half), 16'h0000);
   endtask

   // ==========================================================
   // watchdog
   initial begin
      #160000;
      err_total++;
      results();
   end

   // ==========================================================
   // main sequence
   initial begin
      logic [9:0] codes [5];
      int t10;
      int t8;
      int c3;
      int c;
      codes = '{10'h3FF, 10'h200, 10'h100, 10'h000, 10'h2B7};
      err_total = 0;
      n_tests = 0;
      clk_sys = 1'b0;
      rst_n = 1'b0;
      cfg = '0;
      cfg.divider = 5'h07;
      start_write = 1'b0;
      done_flag_clear = 1'b0;
      vin = 10'h000;
      repeat (16) @(negedge clk_sys);
      rst_n = 1'b1;
      @(negedge clk_sys);
      chk({result_high_byte, result_low_byte}, 16'h0000);
      chk({7'h00, conversion_in_progress, conversion_done_flag, analog_power_on, 6'h00},
          16'h0000);
      cfg.power_on = 1'b1;
      repeat (2) @(negedge clk_sys);
      chk(16'(analog_power_on), 16'h0001);
      gain_check();
      for (int i = 0; i < 5; i++) begin
         for (int m = 0; m < 4; m++) begin
            conv(codes[i], m[0], m[1], 1'b0, c);
            if (m == 0) t10 = c;
            if (m == 2) t8 = c;
         end
         chk(16'(t10 - t8), 16'(2 * 8));
      end
      // six system clocks per sar clock leaves room for the comparator filter
      cfg.divider = 5'h05;
      conv(10'h155, 1'b0, 1'b0, 1'b0, c3);
      chk(16'(t10 - c3), 16'(13 * 2));
      conv(10'h155, 1'b0, 1'b0, 1'b1, c);
      chk(16'(c), 16'(c3));
      abort_run();
      conv(10'h0AA, 1'b1, 1'b0, 1'b0, c);
      results();
   end

endmodule
